/* File: design/edt_pkg.sv */
// Constants for the emergency discharge timer: register map, field layout,
// reset values and the time base derived from the 10 MHz clock.
// Assumes a 32-bit APB master and a synchronous active-high enable input.
package edt_pkg;
    // Printed register index; the byte address is four times it
    localparam logic [7:0] EDT_CFG_INDEX = 8'h1D;
    localparam logic [7:0] EDT_STAT_INDEX = 8'h1E;
    localparam logic [11:0] EDT_CFG_ADDR = {2'b00, EDT_CFG_INDEX, 2'b00};
    localparam logic [11:0] EDT_STAT_ADDR = {2'b00, EDT_STAT_INDEX, 2'b00};
    localparam int EDT_ADDR_W = 12;

    // Field positions in the configuration word
    localparam int EDT_WIN_LSB = 13;
    localparam int EDT_WIN_MSB = 15;
    localparam int EDT_TICK_LSB = 8;
    localparam int EDT_TICK_MSB = 11;
    localparam int EDT_TMO_LSB = 0;
    localparam int EDT_TMO_MSB = 7;
    localparam logic [15:0] EDT_CFG_RESET = 16'h0000;
    localparam logic [2:0] EDT_WIN_RESET = 3'h0;
    localparam logic [7:0] EDT_TMO_RESET = 8'h00;

    // Time base: the cycle is cut into 62.5 ms slots
    localparam int EDT_CLK_PERIOD_NS = 100;
    localparam int EDT_SLOT_NS = 62_500_000;
    localparam int EDT_CYC_PER_SLOT = EDT_SLOT_NS / EDT_CLK_PERIOD_NS;
    localparam int EDT_WIN_UNIT_MS = 7500;
    localparam int EDT_SLOT_US = 62_500;
    localparam int EDT_CYCLE_S = 60;
    localparam int EDT_SLOTS_PER_UNIT = EDT_WIN_UNIT_MS * 1000 / EDT_SLOT_US;
    localparam int EDT_SLOTS_PER_CYCLE = EDT_CYCLE_S * 1_000_000 / EDT_SLOT_US;
    localparam int EDT_TICK_HZ = 2;
    localparam int EDT_SLOTS_PER_TICK = 1_000_000 / (EDT_TICK_HZ * EDT_SLOT_US);
    localparam int EDT_STEP_HOURS = 2;
    // Two hours in microseconds exceeds 32 bits, so the product is formed at 64 bits
    localparam int EDT_SLOTS_PER_STEP = int'(64'd3600 * 64'd1_000_000 * EDT_STEP_HOURS
                                             / EDT_SLOT_US);

    // Counter widths
    localparam int EDT_PRE_W = 20;
    localparam int EDT_SLOT_W = 10;
    localparam int EDT_SUB_W = 3;
    localparam int EDT_STEPCNT_W = 17;
    localparam int EDT_STEP_W = 9;

    typedef enum logic [1:0] {
        EDT_IDLE,
        EDT_RUN,
        EDT_DONE
    } edt_state_e;
endpackage : edt_pkg

/* File: design/edt_timer.sv */
// Emergency discharge timer: on/off window within each 60 s discharge cycle,
// 2 Hz tick counter and 2-hour-step timeout, behind a zero-wait APB slave.
// Assumes the mode enable arrives from another register, synchronous to mclk.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ns

// Overview of operation
// - Window code in bits 15:13 sets switch on-time, 7.5 s per step.
// - Code 0: on 7.5 s, off 52.5 s; code 1: on 15 s, off 45 s.
// - Code 7: on 59.94 s, off only 62.5 ms per cycle.
// - The chosen window applies to every cycle, even and odd alike.
// - While active, a 4-bit tick counter in bits 11:8 advances at 2 Hz.
// - The tick counter wraps fifteen to zero until the mode ends.
// - Tick counter is readable and read-only; writes leave it alone.
// - Timeout code in bits 7:0, one step is 2 hours.
// - Writing timeout zero disables the timer and ends the mode at once.
// - Timer starts on enable with nonzero code, stops at the timeout.
// - Clearing the enable resets the timer.
// - Timeout is two hours times code plus one: 4 h, 6 h ... 512 h.
module edt_timer
    import edt_pkg::*;
#(
    parameter int CYC_PER_SLOT = EDT_CYC_PER_SLOT,
    parameter int SLOTS_PER_STEP = EDT_SLOTS_PER_STEP
) (
    input wire logic mclk, // 10 MHz clock
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [EDT_ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error for unmapped address
    input wire logic emergency_discharge_on, // Mode enable from another register
    output logic discharge_switch_on, // Discharge switches closed
    output logic discharge_active // Mode running, timeout not reached
);

    logic [2:0] win_reg, win_next;
    logic [7:0] tmo_reg, tmo_next;
    logic [3:0] tick_reg, tick_next;
    logic [31:0] prdata_reg, prdata_next;
    logic err_reg, err_next;
    edt_state_e state_reg, state_next;
    logic [EDT_PRE_W-1:0] pre_reg, pre_next;
    logic [EDT_SLOT_W-1:0] slot_reg, slot_next;
    logic [EDT_SUB_W-1:0] sub_reg, sub_next;
    logic [EDT_STEPCNT_W-1:0] stepcnt_reg, stepcnt_next;
    logic [EDT_STEP_W-1:0] step_reg, step_next;
    logic sw_reg, sw_next;

    logic setup_ph, wr_cfg, hit_cfg, hit_stat, tmo_zero_wr;
    logic slot_end, cycle_end, step_end;
    logic [7:0] new_tmo;

    // Number of slots the switches stay on for a window code
    function automatic logic [EDT_SLOT_W-1:0] on_slots(input logic [2:0] code);
        logic [EDT_SLOT_W-1:0] n;
        n = EDT_SLOT_W'(EDT_SLOTS_PER_UNIT) * (EDT_SLOT_W'(code) + 1'b1);
        if (code == 3'h7) begin
            // The full 60 s would leave no gap; keep one slot off
            n = EDT_SLOT_W'(EDT_SLOTS_PER_CYCLE - 1);
        end
        return n;
    endfunction : on_slots

    function automatic logic [15:0] cfg_word(input logic [2:0] w, input logic [3:0] t,
                                             input logic [7:0] m);
        return {w, 1'b0, t, m};
    endfunction : cfg_word

    // Bus decode
    always_comb begin
        setup_ph = psel && !penable;
        hit_cfg = (paddr == EDT_CFG_ADDR);
        hit_stat = (paddr == EDT_STAT_ADDR);
        wr_cfg = psel && penable && pwrite && hit_cfg;
        new_tmo = (wr_cfg && pstrb[0]) ? pwdata[EDT_TMO_MSB:EDT_TMO_LSB] : tmo_reg;
        tmo_zero_wr = wr_cfg && pstrb[0] && (new_tmo == 8'h00);
    end

    // Configuration fields
    always_comb begin
        win_next = win_reg;
        tmo_next = tmo_reg;
        if (wr_cfg && pstrb[1]) begin
            win_next = pwdata[EDT_WIN_MSB:EDT_WIN_LSB];
        end
        if (wr_cfg && pstrb[0]) begin
            tmo_next = pwdata[EDT_TMO_MSB:EDT_TMO_LSB];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            win_reg <= EDT_WIN_RESET;
            tmo_reg <= EDT_TMO_RESET;
        end else begin
            win_reg <= win_next;
            tmo_reg <= tmo_next;
        end
    end

    // Read data is captured in the setup phase so it comes from flip-flops
    always_comb begin
        prdata_next = prdata_reg;
        err_next = 1'b0;
        if (setup_ph) begin
            prdata_next = 32'h0000_0000;
            err_next = !(hit_cfg || hit_stat);
            if (hit_cfg) begin
                prdata_next[15:0] = cfg_word(win_reg, tick_reg, tmo_reg);
            end else if (hit_stat) begin
                prdata_next[1:0] = {sw_reg, state_reg == EDT_RUN};
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
        end else begin
            prdata_reg <= prdata_next;
            err_reg <= err_next;
        end
    end

    // Mode control
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            EDT_IDLE: begin
                if (emergency_discharge_on && new_tmo != 8'h00) begin
                    state_next = EDT_RUN;
                end
            end
            EDT_RUN: begin
                if (!emergency_discharge_on) begin
                    state_next = EDT_IDLE;
                end else if (tmo_zero_wr) begin
                    state_next = EDT_IDLE;
                end else if (step_end && step_reg + 1'b1 >= {1'b0, tmo_reg} + 1'b1) begin
                    state_next = EDT_DONE;
                end
            end
            EDT_DONE: begin
                // Stays off until the enable drops or the timeout is cleared
                if (!emergency_discharge_on || tmo_zero_wr) begin
                    state_next = EDT_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= EDT_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Time base: slots, position in the cycle, 2 Hz ticks and 2 h steps
    always_comb begin
        slot_end = (pre_reg == EDT_PRE_W'(CYC_PER_SLOT - 1));
        cycle_end = slot_end && (slot_reg == EDT_SLOT_W'(EDT_SLOTS_PER_CYCLE - 1));
        step_end = slot_end && (stepcnt_reg == EDT_STEPCNT_W'(SLOTS_PER_STEP - 1));
        pre_next = pre_reg;
        slot_next = slot_reg;
        sub_next = sub_reg;
        stepcnt_next = stepcnt_reg;
        step_next = step_reg;
        tick_next = tick_reg;
        if (state_reg == EDT_RUN && state_next == EDT_RUN) begin
            pre_next = slot_end ? '0 : pre_reg + 1'b1;
            if (slot_end) begin
                // Same window every cycle, so the slot index simply wraps
                slot_next = cycle_end ? '0 : slot_reg + 1'b1;
                sub_next = sub_reg + 1'b1;
                if (sub_reg == EDT_SUB_W'(EDT_SLOTS_PER_TICK - 1)) begin
                    sub_next = '0;
                    tick_next = tick_reg + 1'b1;
                end
                stepcnt_next = step_end ? '0 : stepcnt_reg + 1'b1;
                if (step_end) begin
                    step_next = step_reg + 1'b1;
                end
            end
        end else if (state_next == EDT_IDLE) begin
            pre_next = '0;
            slot_next = '0;
            sub_next = '0;
            stepcnt_next = '0;
            step_next = '0;
            tick_next = 4'h0;
        end
        // In the finished state every counter simply holds
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_reg <= '0;
            slot_reg <= '0;
            sub_reg <= '0;
            stepcnt_reg <= '0;
            step_reg <= '0;
            tick_reg <= EDT_CFG_RESET[EDT_TICK_MSB:EDT_TICK_LSB];
        end else begin
            pre_reg <= pre_next;
            slot_reg <= slot_next;
            sub_reg <= sub_next;
            stepcnt_reg <= stepcnt_next;
            step_reg <= step_next;
            tick_reg <= tick_next;
        end
    end

    // Switch drive, registered to keep the pin glitch free
    always_comb begin
        sw_next = (state_next == EDT_RUN) && (slot_next < on_slots(win_reg));
        if (state_next != EDT_RUN) begin
            sw_next = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sw_reg <= 1'b0;
        end else begin
            sw_reg <= sw_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = psel && penable && err_reg;
    assign discharge_switch_on = sw_reg;
    assign discharge_active = (state_reg == EDT_RUN);

endmodule : edt_timer

/* File: verification/edt_timer_bench.sv */
// Bench for edt_timer: register access, window timing, tick count, timeout.
// Drives every port itself; short slot and step counts keep the run brief.
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module edt_timer_bench;
    import edt_pkg::*;
    localparam int CPS = 4;
    localparam int SPS = 16;
    logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, mode_en = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, seed = 32'h0000_f65a;
    logic [3:0] pstrb = '0;
    logic pready, pslverr, sw_on, act;
    logic [31:0] exp_q[$];
    logic [31:0] exp_v;
    logic [2:0] codes[3] = '{3'h0, 3'h1, 3'h7};
    int failures = 0, n_compared = 0, cyc = 0, n;
    edt_timer #(.CYC_PER_SLOT(CPS), .SLOTS_PER_STEP(SPS)) dut_u (.mclk(mclk),
        .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .emergency_discharge_on(mode_en), .discharge_switch_on(sw_on), .discharge_active(act));
    initial forever #50 mclk = ~mclk;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic wrap_up();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    // Read expectations are queued here and checked by the monitor below
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [31:0] e);
        if (!w) exp_q.push_back(e);
        @(posedge mclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask : apb
    // Counts negedges at which the chosen output keeps level v
    task automatic cnt(input logic v, input logic which, output int k);
        k = 0;
        while (((which ? act : sw_on) === v) && k < 4000) begin
            k++;
            @(negedge mclk);
        end
    endtask : cnt
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc > 60000) begin
            failures++;
            wrap_up();
        end
        // Pop once: the compare macro evaluates its expected argument more than once
        if (psel && penable && pready && !pwrite) begin
            exp_v = exp_q.pop_front();
            `CHK(prdata, exp_v)
        end
    end
    initial begin
        logic [15:0] sh;
        int on;
        repeat (20) @(posedge mclk);
        sys_rst <= 0;
        sh = EDT_CFG_RESET;
        apb(0, EDT_CFG_ADDR, 0, 0, {16'h0, sh});
        // Random lanes and data; tick bits and bit 12 must never stick
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            apb(1, EDT_CFG_ADDR, seed, seed[19:16], 0);
            if (seed[16]) sh[7:0] = seed[7:0];
            if (seed[17]) sh[15:13] = seed[15:13];
            apb(0, EDT_CFG_ADDR, 0, 0, {16'h0, sh});
        end
        apb(0, 12'h07C, 0, 0, 0);
        foreach (codes[j]) begin
            on = (codes[j] == 3'h7) ? 959 * CPS : 120 * (codes[j] + 1) * CPS;
            apb(1, EDT_CFG_ADDR, {16'h0, codes[j], 13'h00FF}, 4'hF, 0);
            @(posedge mclk) mode_en <= 1;
            @(negedge mclk);
            while (sw_on !== 1'b1) @(negedge mclk);
            cnt(1, 0, n);
            `CHK(n, on)
            cnt(0, 0, n);
            `CHK(n, 960 * CPS - on)
            cnt(1, 0, n);
            `CHK(n, on)
            @(posedge mclk) mode_en <= 0;
            repeat (2) @(posedge mclk);
        end
        apb(1, EDT_CFG_ADDR, 32'h0000_00FF, 4'hF, 0);
        @(posedge mclk) mode_en <= 1;
        repeat (14) @(posedge mclk);
        apb(0, EDT_STAT_ADDR, 0, 0, 32'h0000_0003);
        // Reads land mid-tick, so each one sees the next count
        for (int i = 0; i < 18; i++) begin
            apb(0, EDT_CFG_ADDR, 0, 0, {20'h0, 4'(i), 8'hFF});
            repeat (29) @(posedge mclk);
        end
        apb(1, EDT_CFG_ADDR, 0, 4'h1, 0);
        repeat (2) @(posedge mclk);
        @(negedge mclk) `CHK(act, 1'b0)
        for (int t = 1; t < 3; t++) begin
            @(posedge mclk) mode_en <= 0;
            apb(1, EDT_CFG_ADDR, 32'(t), 4'hF, 0);
            @(posedge mclk) mode_en <= 1;
            repeat (2) @(posedge mclk);
            @(negedge mclk) `CHK(act, 1'b1)
            cnt(1, 1, n);
            `CHK(n, (t + 1) * SPS * CPS - 1)
            cnt(0, 1, n);
            `CHK(n, 4000)
            `CHK(sw_on, 1'b0)
        end
        wrap_up();
    end
endmodule : edt_timer_bench

/* File: verification/edt_timer_chk.sv */
// Port checker for edt_timer: APB answers, window edges and mode exits.
// Assumes one clock domain and a bind onto every edt_timer instance.
`timescale 1ns/1ns
module edt_timer_chk
    import edt_pkg::*;
#(
    parameter int CYC_PER_SLOT = 4,
    parameter int SLOTS_PER_STEP = 16
) (
    input wire logic mclk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Access
    input wire logic pwrite, // Direction
    input wire logic [EDT_ADDR_W-1:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [3:0] pstrb, // Strobes
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic emergency_discharge_on, // Enable
    input wire logic discharge_switch_on, // Switches
    input wire logic discharge_active // Mode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic acc;
    logic cfg;
    logic mapped;
    assign acc = psel && penable;
    assign cfg = (paddr == EDT_CFG_ADDR);
    assign mapped = cfg || (paddr == EDT_STAT_ADDR);
    a_ready_high: assert property (pready) else $error("ready low");
    a_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("no error");
    a_err_mapped: assert property (acc && mapped |-> !pslverr) else $error("false error");
    a_rd_upper: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper bits set");
    a_sw_in_mode: assert property (discharge_switch_on |-> discharge_active)
        else $error("switch on outside mode");
    a_start_on: assert property ($rose(discharge_active) |-> discharge_switch_on)
        else $error("cycle starts off");
    a_enable_off: assert property (!emergency_discharge_on |=> !discharge_active)
        else $error("mode outlives enable");
    a_tmo_zero: assert property (acc && pwrite && cfg && pstrb[0] && pwdata[7:0] == 8'h00
        |=> !discharge_active) else $error("zero timeout kept mode");
    a_off_min: assert property ($fell(discharge_switch_on) && discharge_active
        |-> (!discharge_switch_on) [*4]) else $error("off shorter than a slot");
endmodule : edt_timer_chk

bind edt_timer edt_timer_chk #(.CYC_PER_SLOT(CYC_PER_SLOT), .SLOTS_PER_STEP(SLOTS_PER_STEP))
    chk_u (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .emergency_discharge_on(emergency_discharge_on),
    .discharge_switch_on(discharge_switch_on), .discharge_active(discharge_active));
